// [design/tmxd_pkg.sv]
// shared constants and carrier types for the multiplexed transmit backplane splitter
package tmxd_pkg;

  // channels carried by one multiplexed pin
  localparam int unsigned CHANS = 4;
  // mode select code that, with the mux enable, selects the 12.352 Mbit/s input
  localparam logic [1:0] MODE_SEL_MUX = 2'b00;
  // bit positions within one multiplexed frame: 193 octets of 8 bits
  localparam int unsigned POS_W = 11;
  localparam logic [POS_W-1:0] FRAME_LAST_POS = 11'h607;
  localparam logic [POS_W-1:0] FRAME_FIRST_POS = 11'h000;
  // octet that carries the framing bits
  localparam logic [7:0] FRAMING_OCTET = 8'h00;
  // position of the last bit of an octet
  localparam logic [2:0] OCTET_LAST_BIT = 3'h7;
  // first timeslot bit (fifth, counted from zero) whose second copy is signaling
  localparam logic [2:0] SIG_FIRST_BIT = 3'h4;
  // first copy of a doubled bit sits on an even position
  localparam logic COPY_FIRST = 1'b0;
  // elastic store per channel
  localparam int unsigned RING_DEPTH = 16;
  localparam int unsigned RING_AW = 4;
  // words held between the crossing and the channel stores
  localparam int unsigned BUF_DEPTH = 2;
  // synchroniser length
  localparam int unsigned SYNC_STAGES = 2;

  // one octet of the multiplexed stream after the copies are split off
  typedef struct packed {
    logic             is_f;
    logic             has_sig;
    logic [1:0]       sig_sel;
    logic [CHANS-1:0] data;
    logic [CHANS-1:0] sig;
  } tmxd_column_t;

  // one channel's share of a column
  typedef struct packed {
    logic       is_f;
    logic       data;
    logic       has_sig;
    logic [1:0] sig_sel;
    logic       sig;
  } tmxd_slot_t;

  // what each channel's transmit section receives
  typedef struct packed {
    logic       strobe;
    logic       is_f;
    logic       data;
    logic [3:0] abcd;
    logic       underrun;
  } tmxd_chan_out_t;

endpackage

// [design/tmxd_elastic.sv]
// small elastic store with registered read data, one per channel
`timescale 1ns/1ns
module tmxd_elastic
  import tmxd_pkg::*;
#(
  parameter int unsigned WIDTH = $bits(tmxd_slot_t),
  parameter int unsigned DEPTH = RING_DEPTH,
  parameter int unsigned AW    = RING_AW
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // write side
  input  wire logic             wr_valid_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  wr_ready_o,
  // read side
  input  wire logic             rd_req_i,
  output logic                  rd_valid_o,
  output logic [WIDTH-1:0]      rd_data_o,
  output logic                  empty_o
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic             full;
  logic             wr_fire;
  logic             rd_fire;

  // extra pointer bit tells full from empty
  assign full       = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty_o    = (wp == rp);
  assign wr_ready_o = !full;
  assign wr_fire    = wr_valid_i && !full;
  assign rd_fire    = rd_req_i && !empty_o;

  // storage
  always_ff @(posedge clk_i) begin
    if (wr_fire) begin
      mem[wp[AW-1:0]] <= wr_data_i;
    end
  end

  // pointers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (wr_fire) begin
        wp <= wp + 1'b1;
      end
      if (rd_fire) begin
        rp <= rp + 1'b1;
      end
    end
  end

  // read data from a register, valid one cycle after the request
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_o  <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_fire;
      if (rd_fire) begin
        rd_data_o <= mem[rp[AW-1:0]];
      end
    end
  end

endmodule

// [design/tmxd_top.sv]
// splitter for one bit-multiplexed 12.352 Mbit/s transmit backplane stream
`timescale 1ns/1ns
// Overview of operation
// - splitting runs only with mux enable one and mode select 00.
// - serial data enters only on the group's first pin, channel 0 or 4.
// - serial data is sampled on the high-speed clock falling edge.
// - a high frame sync sample marks the frame start.
// - redundant copies dropped; framing, signaling, payload go to own channel.
// - each channel's 1.544 MHz clock moves its bits into its transmit section.
module tmxd_top
  import tmxd_pkg::*;
(
  // system clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  // mode configuration
  input  wire logic                  tx_mux_enable_i,
  input  wire logic [1:0]            tx_mode_select_i,
  // multiplexed link, group's first pin
  input  wire logic                  tx_highspeed_input_clock_i,
  input  wire logic                  tx_serial_data_in_i,
  input  wire logic                  tx_frame_sync_in_i,
  // per-channel 1.544 MHz clocks
  input  wire logic [CHANS-1:0]      tx_line_rate_clock_i,
  // per-channel delivery
  input  wire logic                  status_clear_i,
  output tmxd_chan_out_t [CHANS-1:0] chan_o,
  output logic                       overflow_o,
  output logic                       mode_active_o
);

  // ---------------------------------------------------------------- link side
  logic [SYNC_STAGES-1:0] lrst_sync;
  logic [SYNC_STAGES-1:0] lmode_en_sync;
  logic [1:0]             lmode_sel_m;
  logic [1:0]             lmode_sel_s;
  logic                   lrst;
  logic                   lmode_on;
  logic                   locked;
  logic [POS_W-1:0]       pos;
  logic [POS_W-1:0]       cur_pos;
  logic                   live;
  logic [7:0]             octet;
  logic [2:0]             kbit;
  logic [1:0]             kchan;
  logic [2:0]             ts_bit;
  logic                   sig_pos;
  logic [CHANS-1:0]       col_data;
  logic [CHANS-1:0]       col_sig;
  tmxd_column_t           next_col;
  tmxd_column_t           xfer;
  logic                   req_tgl;
  logic [SYNC_STAGES-1:0] ack_sync_l;
  logic                   busy;
  logic                   emit;
  logic                   lovf;

  // reset and mode reach the link clock through two flops each
  always_ff @(negedge tx_highspeed_input_clock_i) begin
    lrst_sync     <= {lrst_sync[0], srst_i};
    lmode_en_sync <= {lmode_en_sync[0], tx_mux_enable_i};
    lmode_sel_m   <= tx_mode_select_i;
    lmode_sel_s   <= lmode_sel_m;
  end
  assign lrst     = lrst_sync[SYNC_STAGES-1];
  assign lmode_on = lmode_en_sync[SYNC_STAGES-1] && (lmode_sel_s == MODE_SEL_MUX);

  // position of the bit sampled now; a sync sample restarts the frame
  always_comb begin
    if (tx_frame_sync_in_i) begin
      cur_pos = FRAME_FIRST_POS;
    end else if (pos == FRAME_LAST_POS) begin
      cur_pos = FRAME_FIRST_POS;
    end else begin
      cur_pos = pos + 1'b1;
    end
  end
  assign live    = lmode_on && (tx_frame_sync_in_i || locked);
  assign octet   = cur_pos[POS_W-1:3];
  assign kbit    = cur_pos[2:0];
  assign kchan   = kbit[2:1];
  assign ts_bit  = octet[2:0] - 3'h1;  // octet 1 holds timeslot bit zero
  assign sig_pos = (octet != FRAMING_OCTET) && (ts_bit >= SIG_FIRST_BIT);
  assign emit    = live && (kbit == OCTET_LAST_BIT);

  // frame position counter, sampled on the falling edge
  always_ff @(negedge tx_highspeed_input_clock_i) begin
    if (lrst || !lmode_on) begin
      locked <= 1'b0;
      pos    <= FRAME_FIRST_POS;
    end else begin
      if (tx_frame_sync_in_i) begin
        locked <= 1'b1;
      end
      pos <= cur_pos;  // no realignment beyond the sync pulse
    end
  end

  // first copy is data, second copy kept only where it is signaling
  always_ff @(negedge tx_highspeed_input_clock_i) begin
    if (lrst) begin
      col_data <= '0;
      col_sig  <= '0;
    end else if (live) begin
      if (kbit[0] == COPY_FIRST) begin
        col_data[kchan] <= tx_serial_data_in_i;
      end else if (sig_pos) begin
        col_sig[kchan] <= tx_serial_data_in_i;
      end
    end
  end

  // the last bit of an octet completes a column; channel 3's signaling is live
  always_comb begin
    next_col.is_f    = (octet == FRAMING_OCTET);
    next_col.has_sig = sig_pos;
    next_col.sig_sel = ts_bit[1:0];
    next_col.data    = col_data;
    next_col.sig     = {tx_serial_data_in_i, col_sig[CHANS-2:0]};
  end

  // toggle handshake: the column is held until the system side answers
  assign busy = req_tgl ^ ack_sync_l[SYNC_STAGES-1];
  always_ff @(negedge tx_highspeed_input_clock_i) begin
    if (lrst) begin
      req_tgl <= 1'b0;
      xfer    <= '0;
      lovf    <= 1'b0;
    end else if (emit) begin
      if (!busy) begin
        xfer    <= next_col;
        req_tgl <= ~req_tgl;
      end else begin
        lovf <= 1'b1;  // stalled channels cost a column, flagged sticky
      end
    end
  end

  // ---------------------------------------------------------------- system side
  logic                   ack_tgl;
  logic [2:0]             req_sync;
  logic                   pend;
  logic [SYNC_STAGES-1:0] ovf_sync;
  logic [SYNC_STAGES-1:0] mode_sync;
  logic                   buf_wr;

  // acknowledge goes back to the link clock through two flops
  always_ff @(negedge tx_highspeed_input_clock_i) begin
    ack_sync_l <= {ack_sync_l[0], ack_tgl};
  end

  // request toggle synchroniser plus one flop for the edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_sync <= '0;
    end else begin
      req_sync <= {req_sync[1:0], req_tgl};
    end
  end

  // pending column waits here while the buffer is full
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pend    <= 1'b0;
      ack_tgl <= 1'b0;
    end else begin
      if (req_sync[2] ^ req_sync[1]) begin
        pend <= 1'b1;
      end else if (buf_wr) begin
        pend <= 1'b0;
      end
      if (buf_wr) begin
        ack_tgl <= ~ack_tgl;
      end
    end
  end

  // status levels back into the system clock
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ovf_sync  <= '0;
      mode_sync <= '0;
    end else begin
      ovf_sync  <= {ovf_sync[0], lovf};
      mode_sync <= {mode_sync[0], lmode_on};
    end
  end
  assign overflow_o    = ovf_sync[SYNC_STAGES-1];
  assign mode_active_o = mode_sync[SYNC_STAGES-1];

  // two-entry buffer between the crossing and the channel stores
  tmxd_column_t     buf_mem [BUF_DEPTH];
  logic             buf_wp;
  logic             buf_rp;
  logic [1:0]       buf_cnt;
  logic             buf_full;
  logic             buf_valid;
  logic             buf_ready;
  logic             buf_rd;
  logic [CHANS-1:0] ring_ready;
  tmxd_column_t     head;

  assign buf_full  = (buf_cnt == 2'(BUF_DEPTH));
  assign buf_valid = (buf_cnt != 2'h0);
  assign buf_wr    = pend && !buf_full;
  assign buf_ready = &ring_ready;  // any stalled channel holds back all four
  assign buf_rd    = buf_valid && buf_ready;
  assign head      = buf_mem[buf_rp];

  // xfer is stable while pend is set, since the link waits for ack
  always_ff @(posedge clk_i) begin
    if (buf_wr) begin
      buf_mem[buf_wp] <= xfer;
    end
  end

  // buffer pointers and fill count
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (buf_wr) begin
        buf_wp <= ~buf_wp;
      end
      if (buf_rd) begin
        buf_rp <= ~buf_rp;
      end
      buf_cnt <= buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd};
    end
  end

  // ---------------------------------------------------------------- channels
  genvar ch;
  generate
    for (ch = 0; ch < CHANS; ch++) begin : g_chan
      tmxd_slot_t slot_in;
      tmxd_slot_t slot_out;
      logic [2:0] lclk_sync;
      logic       lclk_rise;
      logic       slot_valid;
      logic       ring_empty;

      // split the column out to this channel
      assign slot_in.is_f    = head.is_f;
      assign slot_in.data    = head.data[ch];
      assign slot_in.has_sig = head.has_sig;
      assign slot_in.sig_sel = head.sig_sel;
      assign slot_in.sig     = head.sig[ch];

      // line clock is a pin: two flops, then the edge flop
      // no reset here, so a clock that is high at release gives no false edge
      always_ff @(posedge clk_i) begin
        lclk_sync <= {lclk_sync[1:0], tx_line_rate_clock_i[ch]};
      end
      assign lclk_rise = lclk_sync[1] && !lclk_sync[2];

      // elastic store absorbs the rate difference to the channel clock
      tmxd_elastic u_ring (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .wr_valid_i (buf_rd),
        .wr_data_i  (slot_in),
        .wr_ready_o (ring_ready[ch]),
        .rd_req_i   (lclk_rise),
        .rd_valid_o (slot_valid),
        .rd_data_o  (slot_out),
        .empty_o    (ring_empty)
      );

      // one bit per channel clock into the transmit section
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          chan_o[ch].strobe <= 1'b0;
          chan_o[ch].is_f   <= 1'b0;
          chan_o[ch].data   <= 1'b0;
          chan_o[ch].abcd   <= 4'h0;
        end else begin
          chan_o[ch].strobe <= slot_valid;
          if (slot_valid) begin
            chan_o[ch].is_f <= slot_out.is_f;
            chan_o[ch].data <= slot_out.data;
            if (slot_out.has_sig) begin
              // A lands in bit 3, D in bit 0
              chan_o[ch].abcd[2'h3 - slot_out.sig_sel] <= slot_out.sig;
            end
          end
        end
      end

      // sticky underrun: a channel clock found nothing; set wins over clear
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          chan_o[ch].underrun <= 1'b0;
        end else if (lclk_rise && ring_empty) begin
          chan_o[ch].underrun <= 1'b1;
        end else if (status_clear_i) begin
          chan_o[ch].underrun <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// [verif/tmxd_link_model.sv]
// behavioural terminal equipment driving one multiplexed backplane pin
`timescale 1ns/1ns
module tmxd_link_model (
  // control from the bench
  input  wire logic         run_i,
  input  wire logic [3:0]   stall_i,
  input  wire logic [192:0] frm_i [4],
  input  wire logic [3:0]   sig_i [4],
  // backplane pins
  output logic              lclk_o,
  output logic              sdata_o,
  output logic              sync_o,
  output logic [3:0]        line_o
);
  logic [192:0] frm_q [4];
  logic [3:0]   sig_q [4];
  int           pos, c, k;

  // free-running high-speed clock, 30 ns stand
  // start offset keeps its edges clear of the system clock edges
  initial begin
    lclk_o = 1'b0;
    #7;
    forever #15 lclk_o = ~lclk_o;
  end

  // line clocks at the column rate, edges half a 10 ns step off the sampling edge
  initial begin
    line_o = 4'h0;
    forever begin
      #120 line_o = ~line_o & ~stall_i;
    end
  end

  // data and sync move just after the rising edge; content latched per frame
  initial begin
    pos = 0;
    sdata_o = 1'b0;
    sync_o = 1'b0;
    forever begin
      @(posedge lclk_o);
      #2;
      if (pos == 0) begin
        frm_q = frm_i;
        sig_q = sig_i;
      end
      c = pos % 8 / 2;
      k = pos / 8 - 1;
      sync_o = run_i && pos == 0; // one cycle on the first framing bit
      if (!run_i) sdata_o = ~sdata_o; // idle line keeps moving
      else if (k < 0) sdata_o = frm_q[c][0]; // framing bit twice
      else if (pos % 2 == 1 && k % 8 >= 4) sdata_o = sig_q[c][7 - k % 8]; // A to D
      else sdata_o = frm_q[c][k + 1]; // interleaved payload
      pos = run_i ? (pos + 1) % 1544 : 0;
    end
  end
endmodule

// [verif/tmxd_top_assertions.sv]
// concurrent checks on the multiplexed backplane splitter ports
`timescale 1ns/1ns
module tmxd_top_assertions
  import tmxd_pkg::*;
(
  // clock and reset
  input wire logic                       clk_i,
  input wire logic                       srst_i,
  // watched ports
  input wire logic                       tx_mux_enable_i,
  input wire logic [1:0]                 tx_mode_select_i,
  input wire logic [CHANS-1:0]           tx_line_rate_clock_i,
  input wire logic                       status_clear_i,
  input wire tmxd_chan_out_t [CHANS-1:0] chan_o,
  input wire logic                       overflow_o,
  input wire logic                       mode_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic [5:0] mode_cnt;
  logic       want_q;
  wire logic  want = tx_mux_enable_i && tx_mode_select_i == MODE_SEL_MUX;

  // cycles since the mode inputs settled; both sync chains need about 8
  always_ff @(posedge clk_i) begin
    want_q <= want;
    if (srst_i || want != want_q) mode_cnt <= 6'h00;
    else if (mode_cnt != 6'h3f) mode_cnt <= mode_cnt + 6'h01;
  end

  // a delivered bit leaves a quiet spell behind it
  sequence s_quiet(logic s);
    !s [*8];
  endsequence

  a_mode_follow: assert property (mode_cnt == 6'h1e |-> mode_active_o == want_q)
    else $error("mode flag does not follow mode inputs");
  a_strobe_single: assert property (chan_o[0].strobe |=> s_quiet(chan_o[0].strobe))
    else $error("strobe repeats too soon");
  a_strobe_cause: assert property (chan_o[1].strobe |->
    $past(tx_line_rate_clock_i[1], 2) && !$past(tx_line_rate_clock_i[1], 9))
    else $error("strobe without a line clock rise");
  a_data_hold: assert property ($changed({chan_o[2].data, chan_o[2].is_f}) |->
    chan_o[2].strobe) else $error("channel bit moved without strobe");
  a_abcd_hold: assert property ($changed(chan_o[3].abcd) |->
    chan_o[3].strobe && !chan_o[3].is_f) else $error("signaling moved off a payload slot");
  a_reset_clear: assert property ($fell(srst_i) |-> chan_o == '0 && !overflow_o)
    else $error("outputs not clear after reset");
  a_under_sticky: assert property (chan_o[0].underrun && !status_clear_i |=>
    chan_o[0].underrun) else $error("underrun dropped by itself");
  a_under_cause: assert property ($rose(chan_o[1].underrun) |->
    $past(tx_line_rate_clock_i[1], 1) && !$past(tx_line_rate_clock_i[1], 9))
    else $error("underrun without a line clock rise");
  a_ovf_sticky: assert property (overflow_o |=> overflow_o)
    else $error("overflow dropped before reset");
endmodule

bind tmxd_top tmxd_top_assertions chk_u (
  .clk_i(clk_i), .srst_i(srst_i), .tx_mux_enable_i(tx_mux_enable_i),
  .tx_mode_select_i(tx_mode_select_i), .tx_line_rate_clock_i(tx_line_rate_clock_i),
  .status_clear_i(status_clear_i), .chan_o(chan_o), .overflow_o(overflow_o),
  .mode_active_o(mode_active_o));

// [verif/tmxd_top_bench.sv]
// self-checking bench for the multiplexed backplane splitter
`timescale 1ns/1ns
module tmxd_top_bench
  import tmxd_pkg::*;
;
  localparam int FRM = 4632; // clock cycles per multiplexed frame
  logic                       clk_i = 1'b0;
  logic                       srst_i, en, clr, run, lclk, sd, sy, ovf, mact;
  logic [1:0]                 sel;
  logic [3:0]                 stall, line;
  tmxd_chan_out_t [CHANS-1:0] chan;
  logic [192:0]               frm [4];
  logic [3:0]                 sg [4];
  logic [31:0]                lfsr = 32'hae5018a3;
  int                         fail_count = 0, num_checks = 0, strobes = 0, idx [4];
  bit                         mon = 1'b0, lock [4];

  tmxd_link_model far_u (.run_i(run), .stall_i(stall), .frm_i(frm), .sig_i(sg),
    .lclk_o(lclk), .sdata_o(sd), .sync_o(sy), .line_o(line));
  tmxd_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .tx_mux_enable_i(en),
    .tx_mode_select_i(sel), .tx_highspeed_input_clock_i(lclk), .tx_serial_data_in_i(sd),
    .tx_frame_sync_in_i(sy), .tx_line_rate_clock_i(line), .status_clear_i(clr),
    .chan_o(chan), .overflow_o(ovf), .mode_active_o(mact));

  // 100 MHz system clock
  initial forever #5 clk_i = ~clk_i;

  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // framing flag and bit due at slot i of channel c
  function automatic logic [1:0] exp_slot(int c, int i);
    return {i == 0, frm[c][i]};
  endfunction

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic fill();
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 193; i++) begin
        lfsr = nxt(lfsr);
        frm[c][i] = lfsr[0];
      end
      sg[c] = lfsr[7:4];
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // legal mode for four frames; underrun cleared once data flows
  task automatic run_on();
    en = 1'b1;
    sel = MODE_SEL_MUX;
    mon = 1'b1;
    repeat (2 * FRM) @(negedge clk_i);
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    repeat (2 * FRM) @(negedge clk_i);
    for (int c = 0; c < 4; c++) chk(chan[c].abcd, sg[c]);
    chk({chan[3].underrun, chan[2].underrun, chan[1].underrun, chan[0].underrun}, 4'h0);
    chk(4'(ovf), 4'h0);
  endtask

  // follow each channel's deliveries against the content sent
  always @(negedge clk_i) begin
    for (int c = 0; c < 4; c++) begin
      if (chan[c].strobe === 1'b1) begin
        strobes++;
        if (mon && chan[c].is_f === 1'b1) begin
          lock[c] = 1'b1;
          idx[c] = 0;
        end
        if (mon && lock[c]) begin
          chk({2'h0, chan[c].is_f, chan[c].data}, {2'h0, exp_slot(c, idx[c])});
          idx[c] = (idx[c] + 1) % 193;
        end
      end
    end
  end

  // main sequence
  initial begin
    srst_i = 1'b1;
    en = 1'b0;
    sel = 2'h0;
    clr = 1'b0;
    run = 1'b0;
    stall = 4'h0;
    fill();
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (12) @(negedge clk_i);
    run = 1'b1;
    // enable off with select 00, then select 01 to 11 with enable on, each keeps the channels silent
    for (int m = 0; m < 4; m++) begin
      en = m != 0;
      sel = 2'(m);
      repeat (1200) @(negedge clk_i);
      chk(4'(mact), 4'h0);
    end
    chk(4'(strobes != 0), 4'h0);
    chk({chan[3].underrun, chan[2].underrun, chan[1].underrun, chan[0].underrun}, 4'hf);
    run_on();
    chk(4'(mact), 4'h1);
    // one stalled channel backs up the group until columns drop
    mon = 1'b0;
    lock = '{default: 1'b0};
    stall = 4'h4;
    repeat (FRM) @(negedge clk_i);
    chk(4'(ovf), 4'h1);
    stall = 4'h0;
    // second reset mid-run, fresh content with all-ones corners
    srst_i = 1'b1;
    fill();
    frm[0] = '1;
    sg[3] = 4'hf;
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
    run_on();
    end_sim();
  end

  // watchdog, well past the expected run of about 47000 cycles
  initial begin
    repeat (80000) @(posedge clk_i);
    fail_count++;
    end_sim();
  end
endmodule
